/* logic/spc_core.sv */
// Sync, clocking, output and blanking configuration of one PWM module
//
// Chosen here: the address map and the address-and-strobe port.
`default_nettype none
module spc_core
  import spc_pkg::*;
#(
  parameter int MODULE_ID = 1,
  parameter int N_OUT = 6,
  parameter int TB_W = 16
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Event sources
  input wire logic external_event_input_pin,
  input wire logic [3:0] comparator_synced_result,
  input wire logic [3:0] prd_src_en,
  input wire logic prd_in_en,
  input wire logic [3:0] duty_src_en,
  input wire logic duty_in_en,
  input wire logic [3:0] rise_src_en,
  input wire logic rise_in_en,
  input wire logic [3:0] peer_sync_out,
  input wire logic phase_evt,
  input wire logic [TB_W-1:0] tb_initial,
  // Clock sources
  input wire logic pll_tick,
  input wire logic ext_clk_tick,
  // PWM datapath
  input wire logic [N_OUT-1:0] pwm_raw,
  input wire logic [N_OUT-1:0] port_data,
  // Outputs
  output logic [N_OUT-1:0] pin_out,
  output logic sync_out,
  output logic latch_set,
  output logic module_tick,
  output logic period_evt,
  output logic rise_evt,
  output logic fall_evt,
  output logic [TB_W-1:0] module_time_base_counter
);
  initial begin
    if (N_OUT < 1 || N_OUT > 6) $error("spc_core: N_OUT out of range");
    if (MODULE_ID < 1 || MODULE_ID > 4) $error("spc_core: MODULE_ID out of range");
  end

  localparam logic [7:0] OEN_MASK = (MODULE_ID == 2) ? SPC_MASK_OEN2 : SPC_MASK_OEN6;
  localparam logic [7:0] POL_MASK = (MODULE_ID == 2) ? SPC_MASK_POL2 : SPC_MASK_POL6;

  logic [7:0] sync_reg, clk_reg, oen_reg, pol_reg, blnk_reg, rebs_reg, febs_reg, blen_reg;

  // Register writes; masked bits never store
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_reg <= SPC_RESET_VAL;
      clk_reg <= SPC_RESET_VAL;
      oen_reg <= SPC_RESET_VAL;
      pol_reg <= SPC_RESET_VAL;
      blnk_reg <= SPC_RESET_VAL;
      rebs_reg <= SPC_RESET_VAL;
      febs_reg <= SPC_RESET_VAL;
      blen_reg <= SPC_RESET_VAL;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        SPC_OFS_SYNC: sync_reg <= reg_wdata & SPC_MASK_SYNC;
        SPC_OFS_CLK: clk_reg <= reg_wdata & SPC_MASK_CLK;
        SPC_OFS_OEN: oen_reg <= reg_wdata & OEN_MASK;
        SPC_OFS_POL: pol_reg <= reg_wdata & POL_MASK;
        SPC_OFS_BLNK: blnk_reg <= reg_wdata & SPC_MASK_BLNK;
        SPC_OFS_REBS: rebs_reg <= reg_wdata & SPC_MASK_BS;
        SPC_OFS_FEBS: febs_reg <= reg_wdata & SPC_MASK_BS;
        SPC_OFS_BLEN: blen_reg <= reg_wdata & SPC_MASK_BLEN;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_rd) begin
        unique case (reg_addr)
          SPC_OFS_SYNC: reg_rdata <= sync_reg;
          SPC_OFS_CLK: reg_rdata <= clk_reg;
          SPC_OFS_OEN: reg_rdata <= oen_reg;
          SPC_OFS_POL: reg_rdata <= pol_reg;
          SPC_OFS_BLNK: reg_rdata <= blnk_reg;
          SPC_OFS_REBS: reg_rdata <= rebs_reg;
          SPC_OFS_FEBS: reg_rdata <= febs_reg;
          SPC_OFS_BLEN: reg_rdata <= blen_reg;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Clock source and prescaler
  logic src_tick;
  logic [2:0] pre_cnt;
  logic pre_hit;
  always_comb begin
    unique case (clk_reg[1:0])
      SPC_CSRC_SYS: src_tick = 1'b1;
      SPC_CSRC_PLL: src_tick = pll_tick;
      SPC_CSRC_PIN: src_tick = ext_clk_tick;
      default: src_tick = 1'b0;
    endcase
  end
  always_comb begin
    unique case (clk_reg[5:4])
      2'h0: pre_hit = 1'b1;
      2'h1: pre_hit = pre_cnt[0];
      2'h2: pre_hit = &pre_cnt[1:0];
      default: pre_hit = &pre_cnt;
    endcase
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt <= 3'h0;
    end else if (ce && src_tick) begin
      pre_cnt <= pre_hit ? 3'h0 : pre_cnt + 3'h1;
    end
  end
  assign module_tick = ce && src_tick && pre_hit;

  // Input polarity, then synchronisers
  logic in_act;
  assign in_act = external_event_input_pin ^ pol_reg[SPC_POLIN_BIT];
  spc_src_s src_raw, sync_a, sync_b, sync_c;
  assign src_raw = '{in_pin: in_act, cmp: comparator_synced_result};
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else if (ce) begin
      sync_a <= src_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Blanking windows
  logic re_win, fe_win;
  spc_blank_win #(.LEN_W(8)) u_re_win (
    .mclk(mclk), .resetn(resetn), .ce(ce),
    .mode(blnk_reg[1:0]),
    .length(blen_reg), .edge_evt(rise_evt), .open_win(re_win)
  );
  spc_blank_win #(.LEN_W(8)) u_fe_win (
    .mclk(mclk), .resetn(resetn), .ce(ce),
    .mode(blnk_reg[5:4]),
    .length(blen_reg), .edge_evt(fall_evt), .open_win(fe_win)
  );

  logic [4:0] src_now, src_prev, blank_mask, src_rise;
  assign src_now = {sync_b.in_pin, sync_b.cmp};
  assign src_prev = {sync_c.in_pin, sync_c.cmp};
  assign src_rise = src_now & ~src_prev;
  always_comb begin
    blank_mask = 5'h00;
    if (re_win) blank_mask = blank_mask | {rebs_reg[SPC_BS_IN_BIT], rebs_reg[4:1]};
    if (fe_win) blank_mask = blank_mask | {febs_reg[SPC_BS_IN_BIT], febs_reg[4:1]};
  end

  // Period and duty inversion act on levels; events are rising level changes
  logic [4:0] prd_lvl, prd_prev, duty_lvl, duty_prev;
  assign prd_lvl = src_now ^ {5{sync_reg[SPC_PRPOL_BIT]}};
  assign prd_prev = src_prev ^ {5{sync_reg[SPC_PRPOL_BIT]}};
  assign duty_lvl = src_now ^ {5{sync_reg[SPC_DCPOL_BIT]}};
  assign duty_prev = src_prev ^ {5{sync_reg[SPC_DCPOL_BIT]}};

  logic own_prd, sel_sync, prd_now;
  assign own_prd = |(prd_lvl & ~prd_prev & ~blank_mask & {prd_in_en, prd_src_en});
  always_comb begin
    if (sync_reg[2:0] == SPC_SYNC_OWN || sync_reg[2:0] > SPC_SYNC_MAX) begin
      sel_sync = 1'b0;
    end else begin
      sel_sync = peer_sync_out[2'(sync_reg[2:0] - 3'h1)];
    end
  end
  assign prd_now = own_prd | sel_sync;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      period_evt <= 1'b0;
      rise_evt <= 1'b0;
      fall_evt <= 1'b0;
    end else if (ce) begin
      period_evt <= prd_now;
      rise_evt <= |(src_rise & ~blank_mask & {rise_in_en, rise_src_en});
      fall_evt <= |(duty_lvl & ~duty_prev & ~blank_mask & {duty_in_en, duty_src_en});
    end
  end

  // Phase offset routing
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_out <= 1'b0;
      latch_set <= 1'b0;
    end else if (ce) begin
      if (sync_reg[SPC_POFST_BIT]) begin
        sync_out <= phase_evt;
        latch_set <= prd_now;
      end else begin
        sync_out <= prd_now;
        latch_set <= phase_evt;
      end
    end
  end

  // Time base
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      module_time_base_counter <= '0;
    end else if (ce) begin
      if (period_evt) begin
        module_time_base_counter <= tb_initial;
      end else if (module_tick) begin
        module_time_base_counter <= module_time_base_counter + TB_W'(1);
      end
    end
  end

  // Output stage
  logic [N_OUT-1:0] pwm_pol;
  assign pwm_pol = pwm_raw ^ pol_reg[N_OUT-1:0];
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= '0;
    end else if (ce) begin
      for (int i = 0; i < N_OUT; i++) begin
        pin_out[i] <= oen_reg[i] ? pwm_pol[i] : port_data[i];
      end
    end
  end
endmodule
`default_nettype wire

/* logic/spc_pkg.sv */
// Package of register map, field layout and constants for the PWM sync/blanking configuration block
// Overview of operation
// - Phase-offset bit set: sync out on phase event, latch set on period event.
// - Period-invert bit set inverts selected asynchronous period event inputs.
// - Duty-invert bit set inverts selected asynchronous duty (falling) event inputs.
// - Sync field 000 uses own period event; 001-100 use modules one to four.
// - Prescale field bits 5-4 divide module clock by 1, 2, 4 or 8.
// - Clock source 00 system, 01 PLL, 10 external pin; 11 reserved.
// - Output enable bit routes PWM onto pin; clear leaves ordinary port function.
// - Module two has only outputs A and B; other bits unimplemented.
// - Output polarity bit set makes that output active low.
// - Input polarity bit 6 makes the external event input active low.
// - Falling blank mode bits 5-4: 00 none, 01 immediate; others reserved.
// - Rising blank mode bits 1-0: 00 none, 01 immediate; others reserved.
// - Rising blank mask bits 7 and 4-1 suppress source events while blanking.
// - Falling blank mask bits 7 and 4-1 suppress source events while blanking.
// - Unimplemented bits ignore writes and read zero, including mask bit 0.
// - All implemented bits clear to zero on every reset.
// - A period event restarts the time base counter from its initial count.
`default_nettype none
package spc_pkg;
  localparam logic [2:0] SPC_OFS_SYNC = 3'h0;
  localparam logic [2:0] SPC_OFS_CLK = 3'h1;
  localparam logic [2:0] SPC_OFS_OEN = 3'h2;
  localparam logic [2:0] SPC_OFS_POL = 3'h3;
  localparam logic [2:0] SPC_OFS_BLNK = 3'h4;
  localparam logic [2:0] SPC_OFS_REBS = 3'h5;
  localparam logic [2:0] SPC_OFS_FEBS = 3'h6;
  localparam logic [2:0] SPC_OFS_BLEN = 3'h7;
  localparam logic [7:0] SPC_RESET_VAL = 8'h00;
  localparam logic [7:0] SPC_MASK_SYNC = 8'he7;
  localparam logic [7:0] SPC_MASK_CLK = 8'h33;
  localparam logic [7:0] SPC_MASK_OEN6 = 8'h3f;
  localparam logic [7:0] SPC_MASK_OEN2 = 8'h03;
  localparam logic [7:0] SPC_MASK_POL6 = 8'h7f;
  localparam logic [7:0] SPC_MASK_POL2 = 8'h43;
  localparam logic [7:0] SPC_MASK_BLNK = 8'h33;
  localparam logic [7:0] SPC_MASK_BS = 8'h9e;
  localparam logic [7:0] SPC_MASK_BLEN = 8'hff;
  localparam int SPC_POFST_BIT = 7;
  localparam int SPC_PRPOL_BIT = 6;
  localparam int SPC_DCPOL_BIT = 5;
  localparam int SPC_POLIN_BIT = 6;
  localparam int SPC_BS_IN_BIT = 7;
  localparam logic [2:0] SPC_SYNC_OWN = 3'h0;
  localparam logic [2:0] SPC_SYNC_MAX = 3'h4;
  localparam logic [1:0] SPC_BM_NONE = 2'h0;
  localparam logic [1:0] SPC_BM_IMM = 2'h1;
  localparam logic [1:0] SPC_CSRC_SYS = 2'h0;
  localparam logic [1:0] SPC_CSRC_PLL = 2'h1;
  localparam logic [1:0] SPC_CSRC_PIN = 2'h2;
  localparam int SPC_CLK_MHZ = 50;
  localparam int SPC_PLL_MHZ = 64;
  typedef struct packed {
    logic [7:0] addr_wd;
    logic [2:0] addr;
    logic wr;
    logic rd;
  } spc_bus_s;
  typedef struct packed {
    logic in_pin;
    logic [3:0] cmp;
  } spc_src_s;
  typedef enum logic [1:0] {SPC_BL_IDLE = 2'b00, SPC_BL_OPEN = 2'b01} spc_bl_e;
endpackage
`default_nettype wire

/* logic/spc_blank_win.sv */
// Blanking window timer for one edge
`default_nettype none
module spc_blank_win
  import spc_pkg::*;
#(
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Control
  input wire logic [1:0] mode,
  input wire logic [LEN_W-1:0] length,
  input wire logic edge_evt,
  // Window state
  output logic open_win
);
  spc_bl_e state;
  logic [LEN_W-1:0] cnt;
  initial begin
    if (LEN_W < 1 || LEN_W > 16) $error("spc_blank_win: LEN_W out of range");
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= SPC_BL_IDLE;
      cnt <= '0;
    end else if (ce) begin
      unique case (state)
        SPC_BL_IDLE: begin
          if (mode == SPC_BM_IMM && edge_evt && length != '0) begin
            state <= SPC_BL_OPEN;
            cnt <= length;
          end
        end
        SPC_BL_OPEN: begin
          if (mode != SPC_BM_IMM || cnt == LEN_W'(1)) begin
            state <= SPC_BL_IDLE;
            cnt <= '0;
          end else begin
            cnt <= cnt - LEN_W'(1);
          end
        end
      endcase
    end
  end
  assign open_win = (state == SPC_BL_OPEN);
endmodule
`default_nettype wire

/* verification/spc_core_sva.sv */
// Checker for the PWM sync, clock and output configuration block
`default_nettype none
module spc_core_sva
  import spc_pkg::*;
#(
  parameter int MODULE_ID = 1,
  parameter int N_OUT = 6,
  parameter int TB_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Datapath and events
  input wire logic phase_evt,
  input wire logic [TB_W-1:0] tb_initial,
  input wire logic [N_OUT-1:0] pwm_raw,
  input wire logic [N_OUT-1:0] port_data,
  input wire logic [N_OUT-1:0] pin_out,
  input wire logic sync_out,
  input wire logic latch_set,
  input wire logic period_evt,
  input wire logic [TB_W-1:0] module_time_base_counter
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam bit M2 = MODULE_ID == 2;
  localparam logic [7:0] MSK [8] = '{SPC_MASK_SYNC, SPC_MASK_CLK, M2 ? SPC_MASK_OEN2 : SPC_MASK_OEN6,
    M2 ? SPC_MASK_POL2 : SPC_MASK_POL6, SPC_MASK_BLNK, SPC_MASK_BS, SPC_MASK_BS, SPC_MASK_BLEN};
  logic [N_OUT-1:0] oen;
  logic [N_OUT-1:0] pol;
  logic pofst;
  logic [7:0] msk;
  wire logic [N_OUT-1:0] pin_exp = (oen & (pwm_raw ^ pol)) | (~oen & port_data);
  // Shadow copies of the routing registers, updated only by accepted writes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      oen <= '0;
      pol <= '0;
      pofst <= 1'b0;
      msk <= 8'h00;
    end else if (ce) begin
      msk <= MSK[reg_addr];
      if (reg_wr && reg_addr == SPC_OFS_OEN) oen <= reg_wdata[N_OUT-1:0];
      if (reg_wr && reg_addr == SPC_OFS_POL) pol <= reg_wdata[N_OUT-1:0];
      if (reg_wr && reg_addr == SPC_OFS_SYNC) pofst <= reg_wdata[SPC_POFST_BIT];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_RD_IDLE: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_RD_MASK: assert property (ce && reg_rd |=> (reg_rdata & ~msk) == 8'h00)
    else $error("unimplemented bit read as one");
  AST_PIN_MAP: assert property ($past(resetn, 2) && $past(ce) |-> pin_out == $past(pin_exp))
    else $error("pin routing or polarity wrong");
  AST_RELOAD: assert property (ce && period_evt |=> module_time_base_counter == $past(tb_initial))
    else $error("counter not reloaded");
  // Both pulses are registered from the same period decision, so they stand in one cycle
  AST_SYNC_PRD: assert property (period_evt && !pofst |-> sync_out)
    else $error("sync pulse missing after period");
  AST_LATCH_PRD: assert property (period_evt && pofst |-> latch_set)
    else $error("latch set missing after period");
  AST_SYNC_PH: assert property (phase_evt && pofst |-> ##[1:4] sync_out)
    else $error("sync pulse missing after phase");
  AST_LATCH_PH: assert property (phase_evt && !pofst |-> ##[1:4] latch_set)
    else $error("latch set missing after phase");
  AST_RST_CLEAR: assert property ($rose(resetn) |-> reg_rdata == 8'h00 && pin_out == '0)
    else $error("outputs not clear after reset");
  cover property (phase_evt && pofst);
  cover property (period_evt && !pofst);
  cover property (ce && reg_rd && reg_addr == SPC_OFS_REBS);
endmodule
bind spc_core spc_core_sva #(.MODULE_ID(MODULE_ID), .N_OUT(N_OUT), .TB_W(TB_W)) u_sva (
  .mclk, .resetn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phase_evt, .tb_initial,
  .pwm_raw, .port_data, .pin_out, .sync_out, .latch_set, .period_evt, .module_time_base_counter);
`default_nettype wire

/* verification/spc_stage_model.sv */
// Power stage model: current-sense comparators that follow the switch pins
`default_nettype none
module spc_stage_model #(
  parameter int N_OUT = 6
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Switch drive and sense feedback
  input wire logic [N_OUT-1:0] pin_out,
  output logic [3:0] sense
);
  timeunit 1ns;
  timeprecision 1ps;
  // One cycle of sense lag, so a trip never lands in the same edge as the drive
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sense <= 4'h0;
    end else begin
      sense <= pin_out[3:0];
    end
  end
endmodule
`default_nettype wire

/* verification/spc_core_tb.sv */
// Self-checking bench for the PWM configuration block
`default_nettype none
module spc_core_tb
  import spc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] WV [8] = '{8'hfc, 8'hfe, 8'hff, 8'hff, 8'hdd, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] MSK [8] = '{SPC_MASK_SYNC, SPC_MASK_CLK, SPC_MASK_OEN6, SPC_MASK_POL6,
    SPC_MASK_BLNK, SPC_MASK_BS, SPC_MASK_BS, SPC_MASK_BLEN};
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin = 1'b0;
  logic ien = 1'b0;
  logic phase = 1'b0;
  logic pll = 1'b0;
  logic ext = 1'b0;
  logic [3:0] rise_en = 4'h0;
  logic [3:0] peer = 4'h0;
  logic [3:0] prd_en = 4'h0;
  logic [3:0] duty_en = 4'h0;
  logic rin_en = 1'b0;
  logic [15:0] tbi = 16'h0123;
  logic [5:0] pwm = 6'h00;
  logic [5:0] pdat = 6'h00;
  logic [7:0] cyc = 8'h00;
  logic [3:0] cmp;
  logic [5:0] pin_out;
  logic [7:0] reg_rdata;
  logic [15:0] tbc;
  logic sync_out, latch_set, tick, period_evt, rise_evt, fall_evt;
  int n_ev [6];
  int errors = 0;
  int n_tests = 0;
  spc_core #(.MODULE_ID(1), .N_OUT(6), .TB_W(16)) dut (
    .mclk, .resetn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .external_event_input_pin(pin), .comparator_synced_result(cmp), .prd_src_en(prd_en), .prd_in_en(ien),
    .duty_src_en(duty_en), .duty_in_en(ien), .rise_src_en(rise_en), .rise_in_en(rin_en), .peer_sync_out(peer),
    .phase_evt(phase), .tb_initial(tbi), .pll_tick(pll), .ext_clk_tick(ext), .pwm_raw(pwm),
    .port_data(pdat), .pin_out, .sync_out, .latch_set, .module_tick(tick), .period_evt, .rise_evt,
    .fall_evt, .module_time_base_counter(tbc));
  spc_stage_model #(.N_OUT(6)) stage (.mclk, .resetn, .pin_out, .sense(cmp));
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Source ticks: PLL every second cycle, clock pin every fourth
  always @(posedge mclk) begin
    cyc <= cyc + 8'h01;
    pll <= cyc[0];
    ext <= cyc[1:0] == 2'h0;
  end
  // Counted on the falling edge, where every pulse has settled
  always @(negedge mclk) begin
    n_ev[0] += period_evt;
    n_ev[1] += fall_evt;
    n_ev[2] += sync_out;
    n_ev[3] += latch_set;
    n_ev[4] += tick;
    n_ev[5] += rise_evt;
  end
  task automatic close_out();
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic clr();
    foreach (n_ev[i]) n_ev[i] = 0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask
  // Pin goes high then low; expected period and fall counts after the rise, two events in all
  task automatic trip(input logic [7:0] sv, pv, input int p1, f1);
    wr(SPC_OFS_SYNC, sv);
    wr(SPC_OFS_POL, pv);
    w(8);
    clr();
    pin <= 1'b1;
    w(8);
    chk(n_ev[0], p1);
    chk(n_ev[1], f1);
    pin <= 1'b0;
    w(8);
    chk(n_ev[0] + n_ev[1], 2);
  endtask
  initial begin
    w(10);
    resetn <= 1'b1;
    // Write values keep every field legal while setting all spare bits
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], 8'h00);
      wr(i[2:0], WV[i]);
      rd(i[2:0], WV[i] & MSK[i]);
    end
    w(1);
    resetn <= 1'b0;
    w(3);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    wr(SPC_OFS_OEN, 8'h15);
    wr(SPC_OFS_POL, 8'h33);
    pwm <= 6'h2a;
    pdat <= 6'h0f;
    w(3);
    chk(pin_out, (6'h15 & (6'h2a ^ 6'h33)) | (~6'h15 & 6'h0f));
    for (int s = 0; s < 3; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr(SPC_OFS_CLK, {2'b00, p[1:0], 2'b00, s[1:0]});
        w(20);
        clr();
        w(64);
        chk(n_ev[4], 64 >> (s + p));
      end
    end
    for (int k = 0; k < 5; k++) begin
      tbi <= {k[7:0], 8'h5a};
      wr(SPC_OFS_SYNC, k[7:0]);
      w(4);
      clr();
      for (int j = 0; j < 4; j++) begin
        peer <= 4'h1 << j;
        w(1);
        peer <= 4'h0;
        w(6);
      end
      chk(n_ev[0], k > 0);
    end
    ien <= 1'b1;
    trip(8'h00, 8'h00, 1, 1);
    trip(8'h40, 8'h00, 0, 1);
    trip(8'h20, 8'h00, 1, 0);
    trip(8'h00, 8'h40, 0, 0);
    for (int o = 0; o < 2; o++) begin
      wr(SPC_OFS_SYNC, {o[0], 7'h00});
      clr();
      phase <= 1'b1;
      w(1);
      phase <= 1'b0;
      w(8);
      chk(n_ev[2], o);
      chk(n_ev[3], 1 - o);
    end
    wr(SPC_OFS_POL, 8'h00);
    wr(SPC_OFS_BLEN, 8'h14);
    wr(SPC_OFS_REBS, 8'h80);
    wr(SPC_OFS_BLNK, 8'h01);
    rise_en <= 4'h1;
    rin_en <= 1'b1;
    w(4);
    clr();
    pwm <= 6'h2b;
    w(6);
    pin <= 1'b1;
    w(4);
    pin <= 1'b0;
    w(4);
    chk(n_ev[1], 0);
    chk(n_ev[5], 1);
    w(24);
    pin <= 1'b1;
    w(8);
    chk(n_ev[1], 1);
    chk(n_ev[5], 2);
    // A comparator-two rise raises a fall event that opens the falling window; the pin rise inside it must stay silent
    wr(SPC_OFS_FEBS, 8'h80);
    wr(SPC_OFS_BLNK, 8'h10);
    pin <= 1'b0;
    pdat <= 6'h0d;
    prd_en <= 4'h2;
    duty_en <= 4'h2;
    w(4);
    clr();
    pdat <= 6'h0f;
    w(6);
    pin <= 1'b1;
    w(8);
    chk(n_ev[1], 1);
    chk(n_ev[0], 1);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
